// [core/mts_delta_accum.sv]
// One delta-sum accumulator: adds the size of one-signed sample steps
`default_nettype none
module mts_delta_accum (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Sample stream
  input wire logic sample_valid,
  input wire logic [15:0] cur_count,
  input wire logic [15:0] prev_count,
  input wire logic rising_dir,
  input wire logic clear,
  // Sum
  output logic [15:0] sum_r
);
  import mts_pkg::*;
  logic [15:0] step;
  logic take;
  logic [16:0] wide;

  // Step size in the chosen direction; a step the other way is not taken and leaves the sum unchanged
  always_comb begin
    take = rising_dir ? (cur_count > prev_count) : (cur_count < prev_count);
    step = rising_dir ? 16'(cur_count - prev_count)
                      : 16'(prev_count - cur_count);
    wide = {1'b0, sum_r} + {1'b0, step};
  end

  // Saturate rather than wrap so a large swing never looks small
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sum_r <= RST_COUNT;
    end else if (clear) begin
      sum_r <= RST_COUNT;
    end else if (sample_valid && take) begin
      sum_r <= wide[16] ? 16'hffff : wide[15:0];
    end
  end
endmodule : mts_delta_accum
`default_nettype wire

// [core/mts_pkg.sv]
// Package: register map, field positions and reset values of the motion/touch bank
`default_nettype none
package mts_pkg;
  // Byte register offsets (odd offsets exist, so byte address = 4 * index)
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'h10;
  localparam logic [7:0] IDX_GLOBAL_ACT = 8'h12;
  localparam logic [7:0] IDX_RAMP_FLAGS = 8'h13;
  localparam logic [7:0] IDX_RAW_HI = 8'h22;
  localparam logic [7:0] IDX_RAW_LO = 8'h23;
  localparam logic [7:0] IDX_PDS_HI = 8'h34;
  localparam logic [7:0] IDX_PDS_LO = 8'h35;
  localparam logic [7:0] IDX_NDS_HI = 8'h36;
  localparam logic [7:0] IDX_NDS_LO = 8'h37;
  localparam logic [7:0] IDX_CH0_SETUP = 8'h50;
  localparam logic [7:0] IDX_CH1_SETUP = 8'h51;
  localparam logic [7:0] IDX_GLOBAL_SETUP = 8'h53;
  localparam logic [7:0] IDX_CH0_TUNING = 8'h54;
  localparam logic [7:0] IDX_CH1_TUNING = 8'h55;
  localparam logic [7:0] IDX_EXTRA_SETUP = 8'h57;
  localparam logic [7:0] IDX_PROX_THR = 8'h60;
  localparam logic [7:0] IDX_TOUCH_THR = 8'h61;
  localparam logic [7:0] IDX_MOTION_SETUP = 8'h90;
  localparam logic [7:0] IDX_ENTER_THR = 8'h91;
  localparam logic [7:0] IDX_EXIT_THR = 8'h92;
  localparam logic [7:0] IDX_THR_SCALE = 8'h93;
  // Field positions
  localparam int BIT_EV_TOUCH = 0;
  localparam int BIT_EV_MOTION = 1;
  localparam int BIT_ACT_NEAR = 0;
  localparam int BIT_ACT_CONTACT = 1;
  localparam int BIT_ACT_MOTION = 3;
  localparam int BIT_RAMP_UP = 3;
  localparam int BIT_RAMP_ACTIVE = 4;
  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_THR_ENTER = 8'h10;
  localparam logic [7:0] RST_THR_EXIT = 8'h08;
  localparam logic [7:0] RST_THR_SCALE = 8'h01;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : mts_pkg
`default_nettype wire

// [core/mts_status_regs.sv]
// Motion/touch status and configuration bank behind an AXI4-Lite slave
// Summary of operation
// - Motion trigger sets event flag bit 1
// - Touch activation sets event flag bit 0
// - Motion event shown in activation bit 3
// - Activation bits 0/1: proximity, touch levels
// - Ramp bit 4 high while output changes
// - Ramp bit 3 high rising, low falling
// - Raw count: high byte low address
// - Positive sum grows on rising counts
// - Negative sum grows on falling counts
// - Event when sum exceeds enter times scale
// - Rearm only below exit times scale
// - Channel 1 is motion only; 0 touch
`default_nettype none
module mts_status_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Motion channel (channel 1) samples
  input wire logic ch1_sample_valid,
  input wire logic [15:0] ch1_count,
  // Touch channel (channel 0) two-level activation
  input wire logic near_level_ch_zero,
  input wire logic contact_level_ch_zero,
  // Output generator state
  input wire logic [7:0] pwm_duty,
  // Event outputs
  output logic motion_trip_flag,
  output logic motion_event_flag
);
  import mts_pkg::*;

  // Writable configuration
  logic [7:0] ch0_setup_r, ch1_setup_r, global_setup_r;
  logic [7:0] ch0_tuning_r, ch1_tuning_r, extra_setup_r;
  logic [7:0] prox_thr_r, touch_thr_r, motion_setup_r;
  logic [7:0] enter_thr_r, exit_thr_r, thr_scale_r;
  // Status state
  logic [15:0] raw_count_r, prev_count_r;
  logic [15:0] pos_sum, neg_sum;
  logic [7:0] event_flags_r, global_act_r, ramp_flags_r;
  logic [7:0] prev_duty_r;
  logic duty_seen_r;
  logic armed_r;
  logic have_prev_r;
  logic [15:0] enter_level, exit_level;
  logic sum_clear;
  // Bus state
  logic aw_held_r, w_held_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [7:0] wr_idx, rd_idx;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic rd_hit;

  // Thresholds scaled to delta-sum units
  assign enter_level = 16'(enter_thr_r) * 16'(thr_scale_r);
  assign exit_level = 16'(exit_thr_r) * 16'(thr_scale_r);
  // Trip as soon as either sum passes the enter level while armed
  assign sum_clear = armed_r &&
                     ((pos_sum > enter_level) || (neg_sum > enter_level));

  // Positive and negative sums of the motion channel; channel 1 only
  mts_delta_accum u_pos (
    .mclk(mclk), .arst_n(arst_n),
    .sample_valid(ch1_sample_valid && have_prev_r),
    .cur_count(ch1_count), .prev_count(prev_count_r),
    .rising_dir(1'b1), .clear(1'b0), .sum_r(pos_sum));
  mts_delta_accum u_neg (
    .mclk(mclk), .arst_n(arst_n),
    .sample_valid(ch1_sample_valid && have_prev_r),
    .cur_count(ch1_count), .prev_count(prev_count_r),
    .rising_dir(1'b0), .clear(1'b0), .sum_r(neg_sum));

  // Latest and previous raw counts
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      raw_count_r <= RST_COUNT;
      prev_count_r <= RST_COUNT;
      have_prev_r <= 1'b0;
    end else if (ch1_sample_valid) begin
      raw_count_r <= ch1_count;
      prev_count_r <= ch1_count;
      have_prev_r <= 1'b1;
    end
  end

  // Hysteresis: fire on enter level, rearm below exit level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      armed_r <= 1'b1;
    end else if (sum_clear) begin
      armed_r <= 1'b0;
    end else if (!armed_r && (pos_sum < exit_level) &&
                 (neg_sum < exit_level)) begin
      armed_r <= 1'b1;
    end
  end

  // Event flags follow the current trigger and touch levels
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      event_flags_r <= 8'h00;
      global_act_r <= 8'h00;
      motion_trip_flag <= 1'b0;
      motion_event_flag <= 1'b0;
    end else begin
      event_flags_r <= 8'h00;
      event_flags_r[BIT_EV_MOTION] <= sum_clear;
      event_flags_r[BIT_EV_TOUCH] <= contact_level_ch_zero;
      global_act_r <= 8'h00;
      global_act_r[BIT_ACT_MOTION] <= !armed_r || sum_clear;
      global_act_r[BIT_ACT_NEAR] <= near_level_ch_zero;
      global_act_r[BIT_ACT_CONTACT] <= contact_level_ch_zero;
      motion_trip_flag <= sum_clear;
      motion_event_flag <= !armed_r || sum_clear;
    end
  end

  // Ramp flags from the duty trend; direction held while output is steady
  // No previous duty right after reset, so that cycle is not judged
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_duty_r <= 8'h00;
      duty_seen_r <= 1'b0;
      ramp_flags_r <= 8'h00;
    end else begin
      prev_duty_r <= pwm_duty;
      duty_seen_r <= 1'b1;
      ramp_flags_r[BIT_RAMP_ACTIVE] <= duty_seen_r &&
                                       (pwm_duty != prev_duty_r);
      if (duty_seen_r && (pwm_duty > prev_duty_r)) begin
        ramp_flags_r[BIT_RAMP_UP] <= 1'b1;
      end else if (duty_seen_r && (pwm_duty < prev_duty_r)) begin
        ramp_flags_r[BIT_RAMP_UP] <= 1'b0;
      end
    end
  end

  // Write channel capture; address and data accepted in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end
  assign wr_fire = aw_held_r && w_held_r;
  assign wr_idx = aw_addr_r[9:2];

  // Configuration writes; status indices fall through untouched
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ch0_setup_r <= RST_CFG;
      ch1_setup_r <= RST_CFG;
      global_setup_r <= RST_CFG;
      ch0_tuning_r <= RST_CFG;
      ch1_tuning_r <= RST_CFG;
      extra_setup_r <= RST_CFG;
      prox_thr_r <= RST_CFG;
      touch_thr_r <= RST_CFG;
      motion_setup_r <= RST_CFG;
      enter_thr_r <= RST_THR_ENTER;
      exit_thr_r <= RST_THR_EXIT;
      thr_scale_r <= RST_THR_SCALE;
    end else if (wr_fire && w_strb_r[0] && (aw_addr_r[11:10] == 2'b00)) begin
      if (wr_idx == IDX_CH0_SETUP) begin
        ch0_setup_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_CH1_SETUP) begin
        ch1_setup_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_GLOBAL_SETUP) begin
        global_setup_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_CH0_TUNING) begin
        ch0_tuning_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_CH1_TUNING) begin
        ch1_tuning_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_EXTRA_SETUP) begin
        extra_setup_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_PROX_THR) begin
        prox_thr_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_TOUCH_THR) begin
        touch_thr_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_MOTION_SETUP) begin
        motion_setup_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_ENTER_THR) begin
        enter_thr_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_EXIT_THR) begin
        exit_thr_r <= w_data_r[7:0];
      end else if (wr_idx == IDX_THR_SCALE) begin
        thr_scale_r <= w_data_r[7:0];
      end
    end
  end

  // Write response: OKAY for any index below byte address 0x400, SLVERR above; status writes dropped
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r[11:10] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode; 16-bit values show high byte at the lower index
  assign rd_idx = s_axi_araddr[9:2];
  always_comb begin
    rd_hit = s_axi_araddr[11:10] == 2'b00;
    if (rd_idx == IDX_EVENT_FLAGS) begin
      rd_byte = event_flags_r;
    end else if (rd_idx == IDX_GLOBAL_ACT) begin
      rd_byte = global_act_r;
    end else if (rd_idx == IDX_RAMP_FLAGS) begin
      rd_byte = ramp_flags_r;
    end else if (rd_idx == IDX_RAW_HI) begin
      rd_byte = raw_count_r[15:8];
    end else if (rd_idx == IDX_RAW_LO) begin
      rd_byte = raw_count_r[7:0];
    end else if (rd_idx == IDX_PDS_HI) begin
      rd_byte = pos_sum[15:8];
    end else if (rd_idx == IDX_PDS_LO) begin
      rd_byte = pos_sum[7:0];
    end else if (rd_idx == IDX_NDS_HI) begin
      rd_byte = neg_sum[15:8];
    end else if (rd_idx == IDX_NDS_LO) begin
      rd_byte = neg_sum[7:0];
    end else if (rd_idx == IDX_CH0_SETUP) begin
      rd_byte = ch0_setup_r;
    end else if (rd_idx == IDX_CH1_SETUP) begin
      rd_byte = ch1_setup_r;
    end else if (rd_idx == IDX_GLOBAL_SETUP) begin
      rd_byte = global_setup_r;
    end else if (rd_idx == IDX_CH0_TUNING) begin
      rd_byte = ch0_tuning_r;
    end else if (rd_idx == IDX_CH1_TUNING) begin
      rd_byte = ch1_tuning_r;
    end else if (rd_idx == IDX_EXTRA_SETUP) begin
      rd_byte = extra_setup_r;
    end else if (rd_idx == IDX_PROX_THR) begin
      rd_byte = prox_thr_r;
    end else if (rd_idx == IDX_TOUCH_THR) begin
      rd_byte = touch_thr_r;
    end else if (rd_idx == IDX_MOTION_SETUP) begin
      rd_byte = motion_setup_r;
    end else if (rd_idx == IDX_ENTER_THR) begin
      rd_byte = enter_thr_r;
    end else if (rd_idx == IDX_EXIT_THR) begin
      rd_byte = exit_thr_r;
    end else if (rd_idx == IDX_THR_SCALE) begin
      rd_byte = thr_scale_r;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? {24'h000000, rd_byte} : 32'h0000_0000;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  trip_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
    sum_clear |=> motion_trip_flag && event_flags_r[1])
    else $error("motion trigger flag missing");
  touch_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
    contact_level_ch_zero |=> event_flags_r[0])
    else $error("touch flag missing");
  event_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !armed_r |=> global_act_r[3])
    else $error("motion event flag missing");
  near_level_a: assert property (@(posedge mclk) disable iff (!arst_n)
    1'b1 |=> global_act_r[0] == $past(near_level_ch_zero))
    else $error("proximity level wrong");
  ramp_active_a: assert property (@(posedge mclk) disable iff (!arst_n)
    duty_seen_r && (pwm_duty != prev_duty_r) |=> ramp_flags_r[4])
    else $error("ramp flag missing");
  ramp_down_a: assert property (@(posedge mclk) disable iff (!arst_n)
    duty_seen_r && (pwm_duty < prev_duty_r) |=> !ramp_flags_r[3])
    else $error("ramp direction wrong");
  pos_grow_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ch1_sample_valid && have_prev_r && ch1_count > prev_count_r &&
    pos_sum < 16'h8000 && ch1_count - prev_count_r < 16'h8000
    |=> pos_sum > $past(pos_sum))
    else $error("positive sum did not grow");
  neg_grow_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ch1_sample_valid && have_prev_r && ch1_count < prev_count_r &&
    neg_sum < 16'h8000 && prev_count_r - ch1_count < 16'h8000
    |=> neg_sum > $past(neg_sum))
    else $error("negative sum did not grow");
  no_refire_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !armed_r && (pos_sum >= exit_level || neg_sum >= exit_level)
    |=> !armed_r && !motion_trip_flag)
    else $error("event fired while disarmed");
  ro_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_fire |=> enter_thr_r == $past(enter_thr_r) ||
    $past(wr_idx) == IDX_ENTER_THR)
    else $error("unrelated write changed threshold");
  cov_event_c: cover property (@(posedge mclk) disable iff (!arst_n)
    sum_clear ##[1:50] armed_r);
  cov_write_c: cover property (@(posedge mclk) disable iff (!arst_n)
    wr_fire ##1 s_axi_bvalid);
  cov_read_c: cover property (@(posedge mclk) disable iff (!arst_n)
    s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
endmodule : mts_status_regs
`default_nettype wire

// [verification/mts_host_model.sv]
// Host-side AXI4-Lite master that programs and polls the motion/touch bank
`default_nettype none
module mts_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [11:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [11:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus at time zero
  initial begin
    awvalid = 1'b0;
    awaddr = 12'h000;
    wvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 12'h000;
    rready = 1'b0;
  end

  // One write; released payloads are inverted so stale values never match
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (arst_n !== 1'b1) @(posedge mclk);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_ok = 1'b1;
      end
      if (wvalid && wready === 1'b1) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_ok = 1'b1;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  // One read; data and response are taken at the rvalid edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    while (arst_n !== 1'b1) @(posedge mclk);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : mts_host_model
`default_nettype wire

// [verification/tb_mts_status_regs.sv]
// Self-checking bench for the motion/touch status register bank
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_mts_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import mts_pkg::*;
  logic mclk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ch1_sample_valid;
  logic near_level_ch_zero, contact_level_ch_zero;
  logic motion_trip_flag, motion_event_flag;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] ch1_count;
  logic [7:0] pwm_duty, ramp_step;
  logic [33:0] v;
  int fail_count, checks, trips, t0;

  mts_status_regs dut (.mclk(mclk), .arst_n(arst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ch1_sample_valid(ch1_sample_valid), .ch1_count(ch1_count),
    .near_level_ch_zero(near_level_ch_zero),
    .contact_level_ch_zero(contact_level_ch_zero), .pwm_duty(pwm_duty),
    .motion_trip_flag(motion_trip_flag),
    .motion_event_flag(motion_event_flag));
  mts_host_model host (.mclk(mclk), .arst_n(arst_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  always #5 mclk = ~mclk;
  // Duty ramp generator and trip pulse counter
  always @(posedge mclk) begin
    pwm_duty <= pwm_duty + ramp_step;
    if (motion_trip_flag === 1'b1) trips <= trips + 1;
  end

  // Byte register access: result is {response, data}
  task automatic get(input logic [7:0] i, output logic [33:0] x);
    logic [31:0] d;
    logic [1:0] r;
    host.rd({2'b00, i, 2'b00}, d, r);
    x = {r, d};
  endtask : get
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    host.wr({2'b00, i, 2'b00}, {24'h000000, d}, r);
    `CHK(r, RESP_OKAY)
  endtask : put
  // One motion sample, then idle so flags settle before judging
  task automatic sample(input logic [15:0] c);
    @(posedge mclk);
    ch1_sample_valid <= 1'b1;
    ch1_count <= c;
    @(posedge mclk);
    ch1_sample_valid <= 1'b0;
    ch1_count <= ~c;
    repeat (3) @(posedge mclk);
  endtask : sample

  // Config reset values, then status registers refuse writes
  task automatic t_reset_and_ro();
    logic [7:0] ci [12] = '{8'h50, 8'h51, 8'h53, 8'h54, 8'h55, 8'h57,
      8'h60, 8'h61, 8'h90, 8'h91, 8'h92, 8'h93};
    logic [7:0] cv [12] = '{RST_CFG, RST_CFG, RST_CFG, RST_CFG, RST_CFG,
      RST_CFG, RST_CFG, RST_CFG, RST_CFG, RST_THR_ENTER, RST_THR_EXIT,
      RST_THR_SCALE};
    logic [7:0] si [10] = '{8'h10, 8'h12, 8'h13, 8'h22, 8'h23, 8'h34,
      8'h35, 8'h36, 8'h37, 8'h11};
    for (int i = 0; i < 12; i++) begin
      get(ci[i], v);
      `CHK(v, {RESP_OKAY, 24'h000000, cv[i]})
    end
    for (int i = 0; i < 10; i++) begin
      put(si[i], 8'hff);
      get(si[i], v);
      `CHK(v, {RESP_OKAY, 32'h0000_0000})
    end
    host.rd(12'h800, v[31:0], v[33:32]);
    `CHK(v, {RESP_SLVERR, 32'h0000_0000})
    host.wr(12'h800, 32'h0000_00ff, v[33:32]);
    `CHK(v[33:32], RESP_SLVERR)
  endtask : t_reset_and_ro

  // Host setup per the recommended settings; patterns are arbitrary
  task automatic t_config();
    logic [7:0] wi [8] = '{8'h50, 8'h51, 8'h53, 8'h54, 8'h55, 8'h57,
      8'h60, 8'h61};
    logic [7:0] wv [8] = '{8'h41, 8'h52, 8'ha5, 8'h73, 8'h73, 8'h5a,
      8'h08, 8'h20};
    for (int i = 0; i < 8; i++) put(wi[i], wv[i]);
    put(IDX_MOTION_SETUP, 8'h01);
    for (int i = 0; i < 8; i++) begin
      get(wi[i], v);
      `CHK(v, {RESP_OKAY, 24'h000000, wv[i]})
    end
  endtask : t_config

  // Two-level activation and touch event bits
  task automatic t_activation();
    near_level_ch_zero <= 1'b1;
    get(IDX_GLOBAL_ACT, v);
    `CHK(v[1:0], 2'b01)
    contact_level_ch_zero <= 1'b1;
    get(IDX_GLOBAL_ACT, v);
    `CHK(v[1:0], 2'b11)
    get(IDX_EVENT_FLAGS, v);
    `CHK(v[0], 1'b1)
    near_level_ch_zero <= 1'b0;
    contact_level_ch_zero <= 1'b0;
    get(IDX_EVENT_FLAGS, v);
    `CHK(v[0], 1'b0)
  endtask : t_activation

  // Rising, falling, then steady duty; direction bit holds when steady
  task automatic t_ramp();
    ramp_step <= 8'h01;
    repeat (2) @(posedge mclk);
    get(IDX_RAMP_FLAGS, v);
    `CHK(v[4:3], 2'b11)
    ramp_step <= 8'hff;
    repeat (2) @(posedge mclk);
    get(IDX_RAMP_FLAGS, v);
    `CHK(v[4:3], 2'b10)
    ramp_step <= 8'h00;
    repeat (2) @(posedge mclk);
    get(IDX_RAMP_FLAGS, v);
    `CHK(v[4:3], 2'b00)
  endtask : t_ramp

  // Sums, raw count, trip, disarm and rearm with scaled thresholds
  task automatic t_motion();
    put(IDX_ENTER_THR, 8'h08);
    put(IDX_EXIT_THR, 8'h04);
    put(IDX_THR_SCALE, 8'h02);
    sample(16'h1234);
    sample(16'h1238);
    sample(16'h1230);
    get(IDX_RAW_HI, v);
    `CHK(v[7:0], 8'h12)
    get(IDX_RAW_LO, v);
    `CHK(v[7:0], 8'h30)
    get(IDX_PDS_LO, v);
    `CHK(v[7:0], 8'h04)
    get(IDX_NDS_LO, v);
    `CHK(v[7:0], 8'h08)
    t0 = trips;
    sample(16'h1241);
    `CHK(trips - t0, 1)
    `CHK(motion_event_flag, 1'b1)
    get(IDX_GLOBAL_ACT, v);
    `CHK(v[3], 1'b1)
    sample(16'h1251);
    `CHK(trips - t0, 1)
    put(IDX_ENTER_THR, 8'h40);
    put(IDX_EXIT_THR, 8'h40);
    sample(16'h1252);
    `CHK(motion_event_flag, 1'b0)
    sample(16'h12d2);
    `CHK(trips - t0, 2)
    get(IDX_PDS_LO, v);
    `CHK(v[7:0], 8'ha6)
  endtask : t_motion

  task automatic tally_and_finish();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Main sequence: reset held 20 cycles, then the scenarios
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    ch1_sample_valid = 1'b0;
    ch1_count = 16'h0000;
    near_level_ch_zero = 1'b0;
    contact_level_ch_zero = 1'b0;
    pwm_duty = 8'h80;
    ramp_step = 8'h00;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset_and_ro();
    t_config();
    t_activation();
    t_ramp();
    t_motion();
    tally_and_finish();
  end

  // Watchdog: whole run needs well under a thousand bus cycles
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_mts_status_regs
`default_nettype wire
